//--- dis_pkg.sv
/*
 * Package for the dual integrator sequencer: state codes, timing counts
 * in internal clock periods, and the carrier structs shared by modules.
 * Assumes a single system clock; no registers reachable by software.
 */
package dis_pkg;

    // ------------------------------------------------------------------
    // Timing counts, internal clock periods
    // ------------------------------------------------------------------
    localparam int unsigned MEASURE_CYCLE_LP     = 1552; // low-power variant
    localparam int unsigned MEASURE_CYCLE_HS     = 1612; // high-speed variant
    localparam int unsigned READY_DELAY_CYCLES   = 1382; // both variants
    // Phase split of one measure cycle, low-power variant at 5 MHz
    localparam real         INTERNAL_CLOCK_MHZ   = 5.0;
    localparam real         CONVERTER_PHASE_US   = 135.6;
    localparam real         CONVERTER_RESET_US   = 3.2;
    localparam real         INTEGRATOR_RESET_US  = 36.0;
    localparam int unsigned CONVERTER_PHASE_CYC  =
        int'($floor(CONVERTER_PHASE_US * INTERNAL_CLOCK_MHZ));
    localparam int unsigned CONVERTER_RESET_CYC  =
        int'($floor(CONVERTER_RESET_US * INTERNAL_CLOCK_MHZ));
    localparam int unsigned INTEGRATOR_RESET_CYC =
        int'($floor(INTEGRATOR_RESET_US * INTERNAL_CLOCK_MHZ));
    localparam int unsigned DIVIDE_RATIO         = 4;
    localparam int unsigned INVALID_CONVERSIONS  = 4;
    localparam int          CNT_W                = 12;

    // ------------------------------------------------------------------
    // States, numbered one through eight
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_1 = 3'h0,  // stalled: measure A then B
        ST_2 = 3'h1,  // stalled: prepare A
        ST_3 = 3'h2,  // overlapped: integrate A only
        ST_4 = 3'h3,  // overlapped: integrate B, measure A
        ST_5 = 3'h4,  // overlapped: integrate A, measure B
        ST_6 = 3'h5,  // overlapped: integrate B only
        ST_7 = 3'h6,  // stalled: prepare B
        ST_8 = 3'h7   // stalled: measure B then A
    } dis_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic integrate_a;
        logic integrate_b;
        logic inputs_grounded;
        logic measuring;
        logic measure_side_b;
        logic overlapped;
    } dis_front_t;

    typedef enum logic [1:0] {
        PH_CONVERT = 2'h0,
        PH_CONVERSION_TOGGLE_RST = 2'h1,
        PH_INT_RST = 2'h2,
        PH_IDLE    = 2'h3
    } dis_phase_t;

endpackage : dis_pkg

//--- dis_divider.sv
/*
 * Internal clock enable: every cycle, or every fourth cycle when the
 * divide-by-four input is set. Assumes a synchronous active-low reset.
 */
`timescale 1ns/1ps
module dis_divider
    import dis_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Control
    input  wire logic clock_divide_by_four,
    // Enable out
    output logic      tick
);
    typedef struct packed {
        logic [1:0] cnt;
    } dis_div_state_t;

    dis_div_state_t s_q;
    dis_div_state_t s_d;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    // Counter free-runs so the phase stays fixed while divided
    always_comb begin
        s_d     = s_q;
        s_d.cnt = s_q.cnt + 2'h1;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = !clock_divide_by_four || (s_q.cnt == 2'h3);

endmodule : dis_divider

//--- dis_ready.sv
/*
 * Data-ready output: asserts low after a programmed delay from a start
 * pulse and holds until the readout clock goes high then low.
 * Assumes readout_clock sampled synchronously to the system clock.
 */
`timescale 1ns/1ps
module dis_ready
    import dis_pkg::*;
#(
    parameter int unsigned DELAY = READY_DELAY_CYCLES
)(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic tick,
    // Request
    input  wire logic start,
    input  wire logic readout_clock,
    // Output
    output logic      data_ready_n
);
    typedef struct packed {
        logic             run;
        logic [CNT_W-1:0] cnt;
        logic             ready_n;
        logic             readout_clock_seen;
        logic             readout_clock_prev;
    } dis_rdy_state_t;

    dis_rdy_state_t s_q;
    dis_rdy_state_t s_d;

    // ----------------------------------------------------------------
    // Delay counter and hold
    // ----------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.readout_clock_prev = readout_clock;
        // High then low on readout clock clears the flag
        if (!s_q.ready_n && readout_clock && !s_q.readout_clock_prev) begin
            s_d.readout_clock_seen = 1'b1;
        end
        if (!s_q.ready_n && s_q.readout_clock_seen && !readout_clock) begin
            s_d.ready_n   = 1'b1;
            s_d.readout_clock_seen = 1'b0;
        end
        if (start) begin
            s_d.run = 1'b1;
            s_d.cnt = '0;
        end else if (s_q.run && tick) begin
            if (s_q.cnt == CNT_W'(DELAY - 1)) begin
                s_d.run       = 1'b0;
                s_d.ready_n   = 1'b0;
                s_d.readout_clock_seen = 1'b0; // New data wins over a clear
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q         <= '0;
            s_q.ready_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign data_ready_n = s_q.ready_n;

endmodule : dis_ready

//--- dis_sequencer.sv
/*
 * Integrate/measure sequencer of a dual-integrator current-input
 * converter. Holds the eight-state machine, the measure busy timer and
 * the front-end switch controls; instantiates the clock divider and the
 * data-ready generator. Assumes conversion_toggle and readout_clock are
 * synchronous to clock, and the variant select is static.
 */
// Summary of operation
// - Machine has exactly eight states, one to eight
// - Toggle level and busy decide moves, no edges
// - Busy covers each measure cycle, output as front.measuring
// - Overlapped is states 3-6; 3/6 integrate only
// - Overlapped holds only while busy idle at toggle change
// - Toggle change while busy enters states 1/8
// - Busy ending moves 1 to 2, 8 to 7
// - Stalled states ground the analog inputs
// - Integrations always alternate sides A and B
// - Start state 1 if toggle high, else 8
// - Graph symmetric under toggle inversion
// - State 1 measures A then B; 8 mirrors
// - 4 integrates B measures A; 5 mirrors
// - Two stalled states, then 3/6, then 4/5 alternation
// - Counts in clock periods, times four divided
// - Measure cycle 1552 or 1612 periods
// - Measure length bounds the two modes
// - Ready low 1382 periods after a toggle change that starts a measure
// - Ready holds until readout clock high-low
// - Phase split 135.6, 3.2 and 36 us
// - Divide-by-four gives same internal rate
// - Reset synchronous; data invalid until the fourth measure start, so first three conversions invalid
`timescale 1ns/1ps
module dis_sequencer
    import dis_pkg::*;
#(
    parameter bit          HIGH_SPEED    = 1'b0,
    parameter int unsigned MEASURE_CYCLE =
        HIGH_SPEED ? MEASURE_CYCLE_HS : MEASURE_CYCLE_LP
)(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Configuration
    input  wire logic clock_divide_by_four,
    // Host link
    input  wire logic conversion_toggle,
    input  wire logic readout_clock,
    output logic      data_ready_n,
    // Front end
    output dis_front_t front,
    output dis_phase_t measure_phase,
    output logic      data_invalid
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        dis_state_t       st;
        logic             started;
        logic             busy;
        logic [CNT_W-1:0] mcnt;
        logic             second;     // second side pending in 1/8
        logic             side_b;     // side being measured
        logic             last_conversion_toggle;
        logic [2:0]       conversion_toggle_cnt;
        dis_front_t       fe;
        dis_phase_t       ph;
    } dis_seq_state_t;

    dis_seq_state_t s_q;
    dis_seq_state_t s_d;
    logic           tick;
    logic           rdy_start;
    logic           meas_done;
    logic           conversion_toggle_chg;

    localparam logic [CNT_W-1:0] PH1 = CNT_W'(CONVERTER_PHASE_CYC);
    localparam logic [CNT_W-1:0] PH2 =
        CNT_W'(CONVERTER_PHASE_CYC + CONVERTER_RESET_CYC);

    // Mirror of a state under toggle inversion
    function automatic dis_state_t mirror(input dis_state_t s);
        mirror = dis_state_t'(3'h7 - s);
    endfunction : mirror

    // Measure phase from elapsed count, same fixed bounds for either cycle length
    function automatic dis_phase_t phase_of(input logic [CNT_W-1:0] c);
        if (c < PH1) begin
            phase_of = PH_CONVERT;
        end else if (c < PH2) begin
            phase_of = PH_CONVERSION_TOGGLE_RST;
        end else begin
            phase_of = PH_INT_RST;
        end
    endfunction : phase_of

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    dis_divider u_div (
        .clock                (clock),
        .rstn                 (rstn),
        .clock_divide_by_four (clock_divide_by_four),
        .tick                 (tick)
    );

    dis_ready #(
        .DELAY (READY_DELAY_CYCLES)
    ) u_rdy (
        .clock         (clock),
        .rstn          (rstn),
        .tick          (tick),
        .start         (rdy_start),
        .readout_clock (readout_clock),
        .data_ready_n  (data_ready_n)
    );

    // Level compare, never an edge detector on the raw pin
    assign conversion_toggle_chg  = s_q.started && tick
                       && (conversion_toggle != s_q.last_conversion_toggle);
    assign meas_done = s_q.busy && tick
                       && (s_q.mcnt == CNT_W'(MEASURE_CYCLE - 1));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        rdy_start = 1'b0;
        if (!s_q.started) begin
            // First cycle after reset release reads the toggle level
            s_d.started   = 1'b1;
            s_d.last_conversion_toggle = conversion_toggle;
            s_d.st        = conversion_toggle ? ST_1 : ST_8;
            s_d.busy      = 1'b0;
            s_d.second    = 1'b0;
        end else if (tick) begin
            s_d.last_conversion_toggle = conversion_toggle;
            // Measure timer runs on the internal clock enable
            if (s_q.busy) begin
                s_d.mcnt = s_q.mcnt + CNT_W'(1);
            end
            if (meas_done) begin
                s_d.mcnt = '0;
                if (s_q.second) begin
                    s_d.second = 1'b0;
                    s_d.side_b = !s_q.side_b;
                end else begin
                    s_d.busy = 1'b0;
                end
            end
            // Transitions from toggle level and busy only
            unique case (s_q.st)
                ST_1, ST_8: begin
                    if (!s_d.busy) begin
                        s_d.st = (s_q.st == ST_1) ? ST_2 : ST_7;
                    end
                end
                ST_2, ST_7: begin
                    // Level that ends the previous side starts the next
                    if (conversion_toggle_chg) begin
                        s_d.st = (s_q.st == ST_2) ? ST_3 : ST_6;
                    end
                end
                ST_3, ST_6: begin
                    if (conversion_toggle_chg) begin
                        s_d.st     = (s_q.st == ST_3) ? ST_4 : ST_5;
                        s_d.busy   = 1'b1;
                        s_d.mcnt   = '0;
                        s_d.side_b = (s_q.st == ST_6);
                        rdy_start  = 1'b1;
                    end
                end
                ST_4, ST_5: begin
                    if (conversion_toggle_chg) begin
                        if (s_q.busy && !meas_done) begin
                            // Integration shorter than measure cycle
                            s_d.st     = (s_q.st == ST_4) ? ST_1 : ST_8;
                            s_d.second = 1'b1;
                        end else begin
                            s_d.st     = mirror(s_q.st);
                            s_d.busy   = 1'b1;
                            s_d.mcnt   = '0;
                            s_d.side_b = (s_q.st == ST_4);
                            rdy_start  = 1'b1;
                        end
                    end
                end
            endcase
            if (s_d.st == ST_4 || s_d.st == ST_5 || s_d.st == ST_3
                || s_d.st == ST_6) begin
                if (rdy_start && s_q.conversion_toggle_cnt != 3'(INVALID_CONVERSIONS))
                begin
                    s_d.conversion_toggle_cnt = s_q.conversion_toggle_cnt + 3'h1;
                end
            end
        end
        // Front-end controls follow the next state
        s_d.fe.integrate_a     = (s_d.st == ST_3) || (s_d.st == ST_5);
        s_d.fe.integrate_b     = (s_d.st == ST_4) || (s_d.st == ST_6);
        s_d.fe.overlapped      = (s_d.st >= ST_3) && (s_d.st <= ST_6);
        s_d.fe.inputs_grounded = !s_d.fe.overlapped;
        s_d.fe.measuring       = s_d.busy;
        s_d.fe.measure_side_b  = s_d.side_b;
        s_d.ph = s_d.busy ? phase_of(s_d.mcnt) : PH_IDLE;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Synchronous reset: the start state is taken after release
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q    <= '0;
            s_q.st <= ST_1;
            s_q.ph <= PH_IDLE;
            s_q.fe.inputs_grounded <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign front         = s_q.fe;
    assign measure_phase = s_q.ph;
    assign data_invalid  = (s_q.conversion_toggle_cnt != 3'(INVALID_CONVERSIONS));

endmodule : dis_sequencer

//--- dis_checker.sv
/* Port checker for the sequencer: mode flags, ready timing, alternation.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ps
module dis_checker
    import dis_pkg::*;
#(
    parameter int unsigned MEASURE_CYCLE = MEASURE_CYCLE_LP
)(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // Observed ports
    input wire logic       clock_divide_by_four,
    input wire logic       conversion_toggle,
    input wire logic       readout_clock,
    input wire logic       data_ready_n,
    input wire dis_front_t front
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [13:0] busy_cnt;
    logic [3:0]  rc_age;
    logic [1:0]  last_side;   // 1 = A, 2 = B, 0 = none yet
    logic        meas_q;      // measuring, one cycle back
    logic        rdy_q;       // data_ready_n, one cycle back
    logic        rdy_arm;     // a measure start awaits its ready
    logic [11:0] rdy_cnt;     // cycles since that start

    // Busy run length, age of readout high, last side integrated
    always_ff @(posedge clock) begin
        if (!rstn || !front.measuring) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= busy_cnt + 14'h1;
        end
        if (!rstn) begin
            rc_age    <= 4'hf;
            last_side <= 2'h0;
            meas_q    <= 1'b0;
            rdy_q     <= 1'b1;
            rdy_arm   <= 1'b0;
            rdy_cnt   <= '0;
        end else begin
            rc_age    <= readout_clock ? 4'h0
                         : rc_age + {3'h0, rc_age != 4'hf};
            last_side <= front.integrate_a ? 2'h1 :
                         front.integrate_b ? 2'h2 : last_side;
            meas_q    <= front.measuring;
            rdy_q     <= data_ready_n;
            // Counter keeps the long ready window cheap to check
            if (front.measuring && !meas_q && front.overlapped
                && !clock_divide_by_four) begin
                rdy_arm <= 1'b1;
                rdy_cnt <= '0;
            end else if (rdy_arm) begin
                rdy_arm <= !(rdy_q && !data_ready_n);
                rdy_cnt <= rdy_cnt + 12'h001;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------
    // Ready falling while a measure start is still awaiting it
    sequence s_ready_fall;
        rdy_arm && $fell(data_ready_n);
    endsequence

    a_ground_stalled: assert property (
        (front.inputs_grounded != front.overlapped) &&
        (front.inputs_grounded == !(front.integrate_a || front.integrate_b)))
        else $error("grounding does not match mode");
    a_meas_overlap: assert property (front.overlapped && front.measuring |->
        (front.integrate_a ^ front.integrate_b) &&
        (front.measure_side_b == front.integrate_a))
        else $error("overlapped measure on wrong side");
    // Fall sampled 1382 cycles after the start; the count lags by one
    a_ready_delay: assert property (s_ready_fall |->
        rdy_cnt >= 12'h561 && rdy_cnt <= 12'h569)
        else $error("ready not at measure delay");
    a_ready_late: assert property (rdy_arm |-> rdy_cnt <= 12'h569)
        else $error("ready missing after measure start");
    a_ready_holds: assert property ($rose(data_ready_n) |-> rc_age < 4'h6)
        else $error("ready cleared without readout pulse");
    a_busy_length: assert property ($fell(front.measuring) &&
        $past(front.overlapped) && !clock_divide_by_four |->
        busy_cnt >= MEASURE_CYCLE - 2 && busy_cnt <= MEASURE_CYCLE + 2)
        else $error("measure cycle length wrong");
    a_toggle_stall: assert property ($changed(conversion_toggle) &&
        front.measuring && front.overlapped |->
        ##[1:6] !front.overlapped && front.inputs_grounded)
        else $error("busy toggle did not stall");
    a_prepare_resume: assert property ($changed(conversion_toggle) &&
        front.inputs_grounded && !front.measuring |->
        ##[1:12] front.overlapped)
        else $error("prepared side did not integrate");
    a_side_alternate: assert property (($rose(front.integrate_a) ||
        $rose(front.integrate_b)) |->
        last_side != (front.integrate_a ? 2'h1 : 2'h2))
        else $error("integration repeated a side");
endmodule : dis_checker

bind dis_sequencer dis_checker #(.MEASURE_CYCLE(MEASURE_CYCLE)) i_dis_checker (
    .clock(clock), .rstn(rstn), .clock_divide_by_four(clock_divide_by_four),
    .conversion_toggle(conversion_toggle), .readout_clock(readout_clock),
    .data_ready_n(data_ready_n), .front(front));

//--- dis_host_model.sv
/* Host partner: toggle follows a bench level, ready answered by one
   readout pulse, prompt or slow. Assumes the bench clock and reset. */
`timescale 1ns/1ps
module dis_host_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Bench commands
    input  wire logic conversion_toggle_req,
    input  wire logic slow,
    // Device pins
    input  wire logic data_ready_n,
    output logic      conversion_toggle,
    output logic      readout_clock
);
    logic [7:0] wait_q;
    logic       armed_q;

    // Bench sets level spacing, so the toggle is a plain follower
    assign conversion_toggle = conversion_toggle_req;

    // One high-low pulse per ready; re-armed only once ready clears
    always @(posedge clock) begin
        if (!rstn) begin
            wait_q        <= 8'h00;
            armed_q       <= 1'b1;
            readout_clock <= 1'b0;
        end else if (wait_q != 8'h00) begin
            wait_q        <= wait_q - 8'h01;
            readout_clock <= (wait_q == 8'h03) || (wait_q == 8'h02);
        end else if (!data_ready_n && armed_q) begin
            wait_q  <= slow ? 8'h40 : 8'h04;
            armed_q <= 1'b0;
        end else if (data_ready_n) begin
            armed_q <= 1'b1;
        end
    end
endmodule : dis_host_model

//--- dis_sequencer_tb.sv
/* Bench for the sequencer with the host model; scenario tasks.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module dis_sequencer_tb
    import dis_pkg::*;
;
    logic       clock;
    logic       rstn;
    logic       clock_divide_by_four;
    logic       conversion_toggle_req;
    logic       slow;
    logic       conversion_toggle;
    logic       readout_clock;
    logic       data_ready_n;
    dis_front_t front;
    dis_phase_t measure_phase;
    logic       data_invalid;
    int         err_count = 0;
    int         check_count = 0;
    int         cyc = 0;

    dis_sequencer i_dis_sequencer (.clock(clock), .rstn(rstn),
        .clock_divide_by_four(clock_divide_by_four),
        .conversion_toggle(conversion_toggle), .readout_clock(readout_clock),
        .data_ready_n(data_ready_n), .front(front),
        .measure_phase(measure_phase), .data_invalid(data_invalid));
    dis_host_model i_dis_host_model (.clock(clock), .rstn(rstn),
        .conversion_toggle_req(conversion_toggle_req), .slow(slow), .data_ready_n(data_ready_n),
        .conversion_toggle(conversion_toggle), .readout_clock(readout_clock));

    // 250 MHz system clock
    always #2 clock = ~clock;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // Flags a,b,grounded,measuring,side_b,overlapped under a mask
    task automatic chk_front(input logic [5:0] exp, input logic [5:0] m);
        check("front", 32'(front & m), 32'(exp));
    endtask : chk_front

    task automatic do_reset(input logic tog, input logic div);
        rstn                 <= 1'b0;
        conversion_toggle_req             <= tog;
        clock_divide_by_four <= div;
        tick(10);
        rstn <= 1'b1;
    endtask : do_reset

    // Bounded wait; count of edges until ready seen low
    task automatic wait_ready(output int n);
        n = 0;
        while (data_ready_n !== 1'b0 && n < 8000) begin
            tick(1);
            n++;
        end
    endtask : wait_ready

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_overlap;
        int n;
        do_reset(1'b0, 1'b0);
        tick(4);
        chk_front(6'h08, 6'h3b);
        conversion_toggle_req <= 1'b1;
        tick(4);
        chk_front(6'h11, 6'h3f);
        check("phase idle", 32'(measure_phase), 32'(PH_IDLE));
        tick(1600);
        conversion_toggle_req <= 1'b0;
        wait_ready(n);
        check("ready delay", 32'(n >= 1380 && n <= 1388), 32'h1);
        chk_front(6'h27, 6'h3f);
        tick(12);
        check("ready cleared", 32'(data_ready_n), 32'h1);
        tick(200);
        check("busy done", 32'(front.measuring), 32'h0);
        conversion_toggle_req <= 1'b1;
        tick(3);
        chk_front(6'h15, 6'h3f);
        check("phase", 32'(measure_phase), 32'(PH_CONVERT));
        check("invalid", 32'(data_invalid), 32'h1);
    endtask : t_overlap

    // Toggle while side A is still being measured, slow host
    task automatic t_stall;
        int n;
        slow <= 1'b1;
        wait_ready(n);
        tick(100);
        conversion_toggle_req <= 1'b0;
        tick(3);
        chk_front(6'h08, 6'h3b);
        n = 0;
        while (front.measuring !== 1'b0 && n < 4000) begin
            tick(1);
            n++;
        end
        tick(3);
        chk_front(6'h0a, 6'h3f);
        conversion_toggle_req <= 1'b1;
        tick(3);
        chk_front(6'h21, 6'h3d);
        slow <= 1'b0;
    endtask : t_stall

    // Reset in mid-run with the toggle high, mirror path
    task automatic t_boot_high;
        do_reset(1'b1, 1'b0);
        tick(4);
        chk_front(6'h08, 6'h3b);
        conversion_toggle_req <= 1'b0;
        tick(3);
        chk_front(6'h21, 6'h3f);
        tick(1500);
        check("no ready", 32'(data_ready_n), 32'h1);
    endtask : t_boot_high

    // Divided clock: every count four times longer
    task automatic t_divide;
        int n;
        do_reset(1'b0, 1'b1);
        slow <= 1'b1;
        tick(40);
        conversion_toggle_req <= 1'b1;
        tick(6400);
        conversion_toggle_req <= 1'b0;
        wait_ready(n);
        check("div delay", 32'(n >= 5524 && n <= 5540), 32'h1);
        tick(100);
        check("div cleared", 32'(data_ready_n), 32'h1);
    endtask : t_divide

    task automatic complete_run;
        $display("checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // Hang guard, well above the total scenario length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        clock                = 1'b0;
        rstn                 = 1'b0;
        clock_divide_by_four = 1'b0;
        conversion_toggle_req             = 1'b0;
        slow                 = 1'b0;
        t_overlap();
        t_stall();
        t_boot_high();
        t_divide();
        complete_run();
    end
endmodule : dis_sequencer_tb
